//--- logic/itc_pkg.sv
package itc_pkg;
   // the register's index; its byte address is four times that, data in byte lane 0
   localparam logic [11:0] ITC_ADDR_COMMON = 12'hd01;
   localparam logic [13:0] ITC_ADDR_BYTE = {ITC_ADDR_COMMON, 2'b00};
   localparam int ITC_LANE = 0;
   localparam logic [7:0] ITC_RESET_VAL = 8'h00;
   localparam int ITC_BIT_MODE = 7;
   localparam int ITC_BIT_SEL = 6;
   localparam int ITC_FLD_HI = 5;
   localparam int ITC_FLD_LO = 4;
   localparam int ITC_SUB_HI = 3;
   localparam int ITC_SUB_LO = 2;
   localparam int ITC_BIT_ONE = 1;
   localparam int ITC_BIT_ZERO = 0;
   localparam int ITC_IRQ_MASK_BIT = 2;
   localparam int ITC_SCLK_NS = 5;
   localparam int ITC_FILT_SHORT_CYC = 4;
   localparam int ITC_FILT_LONG_CYC = 8;
   localparam logic [1:0] ITC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ITC_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0]
   {
      ITC_LOG_AND = 2'h0,
      ITC_LOG_OR = 2'h1,
      ITC_LOG_NOR = 2'h2,
      ITC_LOG_NAND = 2'h3
   } itc_logic_t;
   typedef enum logic [1:0]
   {
      ITC_SUB_NORMAL = 2'h0,
      ITC_SUB_ALT = 2'h1,
      ITC_SUB_FORCE_LO = 2'h2,
      ITC_SUB_FORCE_HI = 2'h3
   } itc_sub_t;
   typedef enum logic [1:0]
   {
      ITC_EDGE_FALL = 2'h0,
      ITC_EDGE_RISE = 2'h1,
      ITC_EDGE_BOTH = 2'h2,
      ITC_EDGE_RSVD = 2'h3
   } itc_edge_t;
   typedef enum logic [1:0]
   {
      ITC_FILT_NONE = 2'h0,
      ITC_FILT_SHORT = 2'h1,
      ITC_FILT_LONG = 2'h2,
      ITC_FILT_RSVD = 2'h3
   } itc_filt_t;
endpackage

//--- logic/itc_filt_if.sv
`timescale 1ns/1ps
interface itc_filt_if;
   logic raw;
   logic [1:0] sel;
   logic clean;
   modport ctl (output raw, output sel, input clean);
   modport flt (input raw, input sel, output clean);
endinterface

//--- logic/itc_glitch_filter.sv
`timescale 1ns/1ps
module itc_glitch_filter
   import itc_pkg::*;
#(
   parameter int CNT_W = 4
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   itc_filt_if.flt f
);
   initial
   begin
      if ((1 << CNT_W) <= ITC_FILT_LONG_CYC)
         $error("itc_glitch_filter: counter too narrow");
   end
   logic clean_q, clean_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] lim;
   // a change passes only after it outlives the window, so pulses of the window width are dropped
   always_comb
   begin
      lim = CNT_W'(ITC_FILT_SHORT_CYC);
      if (f.sel == ITC_FILT_LONG)
         lim = CNT_W'(ITC_FILT_LONG_CYC);
      clean_d = clean_q;
      cnt_d = '0;
      if (f.sel == ITC_FILT_NONE || f.sel == ITC_FILT_RSVD)
         clean_d = f.raw;
      else if (f.raw != clean_q)
      begin
         if (cnt_q >= lim) // R11 R15
            clean_d = f.raw;
         else
            cnt_d = cnt_q + CNT_W'(1);
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         clean_q <= 1'b0;
         cnt_q <= '0;
      end
      else
      begin
         clean_q <= clean_d;
         cnt_q <= cnt_d;
      end
   end
   assign f.clean = clean_q;
endmodule

//--- logic/itc_common_functions.sv
// Notes on behaviour
// R1 - top bit picks transmit (0) or demodulation (1) mode.
// R2 - software disables both timers before switching mode.
// R3 - transmit: bit 6 puts combined timer output on port3_pin6.
// R4 - demodulation: bit 6 picks port3_pin1 (0) or port2_pin0 (1) input.
// R5 - port3_pin1 input with mask bit 2 set also raises interrupt one.
// R6 - transmit: bits 5:4 combine outputs as AND, OR, NOR, NAND.
// R7 - bits 5:4 survive stop mode recovery.
// R8 - demodulation: bits 5:4 choose falling, rising or both edges.
// R9 - transmit: bits 3:2 normal, alternating, force low, force high.
// R10 - writing normal/alternating: sixteen-bit output is inverse of bit 0 until counting.
// R11 - demodulation: bits 3:2 none, 4-cycle or 8-cycle glitch filter.
// R12 - register read/write at d01, resets to zero.
// R13 - bits 1:0 initial levels; disabled timer drives the opposite level (code: sixteen-bit timer only while held after a normal/alternating write).
// R14 - demodulation: bit 1 rising flag, bit 0 falling; write 1 clears.
// R15 - input synchronised, passed after outlasting filter width.
`timescale 1ns/1ps
module itc_common_functions
   import itc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic stop_recovery,
   input wire logic [13:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [13:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic eight_bit_timer_output,
   input wire logic sixteen_bit_timer_output,
   input wire logic eight_bit_timer_enabled,
   input wire logic sixteen_bit_timer_counting,
   input wire logic port3_pin6_port_data,
   input wire logic port3_pin1,
   input wire logic port2_pin0,
   input wire logic [7:0] interrupt_mask_register,
   output logic port3_pin6,
   output logic eight_bit_timer_level,
   output logic sixteen_bit_timer_level,
   output logic alternating_active,
   output logic demod_input,
   output logic external_interrupt_one,
   output logic demod_event
);
   logic [7:0] reg_q, reg_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic awrdy_q, wrdy_q, arrdy_q;
   logic [13:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0] ws_q, ws_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic p31_s1_q, p31_s2_q, p20_s1_q, p20_s2_q;
   logic clean_prev_q, clean_prev_d;
   logic eight_hold_q, sixteen_hold_q, eight_hold_d, sixteen_hold_d;
   logic p36_q, p36_d, t8l_q, t8l_d, t16l_q, t16l_d, alt_q, alt_d;
   logic din_q, din_d, irq_q, irq_d, ev_q, ev_d;
   logic wr_go, wr_hit;
   logic [7:0] wbyte;
   logic rise, fall, comb, t8_eff, t16_eff;

   itc_filt_if filt ();

   itc_glitch_filter #(.CNT_W(4)) u_filt
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .f(filt)
   );

   // bus slave: address and data taken in either order, answer one cycle after both
   assign wr_go = aw_q && w_q && !bv_q;
   assign wr_hit = wr_go && awa_q == ITC_ADDR_BYTE && ws_q[ITC_LANE];
   assign wbyte = wd_q[ITC_LANE*8 +: 8];

   always_comb
   begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_awvalid && !aw_q)
      begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q)
      begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_go)
      begin
         bv_d = 1'b1;
         br_d = (awa_q == ITC_ADDR_BYTE) ? ITC_RESP_OKAY : ITC_RESP_SLVERR;
      end
      if (bv_q && s_axi_bready)
      begin
         bv_d = 1'b0;
         aw_d = 1'b0;
         w_d = 1'b0;
      end
      if (s_axi_arvalid && !rv_q)
      begin
         rv_d = 1'b1;
         rd_d = '0;
         rr_d = ITC_RESP_SLVERR;
         if (s_axi_araddr == ITC_ADDR_BYTE)
         begin
            rd_d[ITC_LANE*8 +: 8] = reg_q;
            rr_d = ITC_RESP_OKAY;
         end
      end
      else if (rv_q && s_axi_rready)
         rv_d = 1'b0;
   end

   // register: write, edge flags set by hardware win over a clear in the same cycle
   always_comb
   begin
      reg_d = reg_q;
      if (wr_hit)
      begin
         reg_d = wbyte; // R12
         if (reg_q[ITC_BIT_MODE] && wbyte[ITC_BIT_MODE])
         begin
            reg_d[ITC_BIT_ONE] = reg_q[ITC_BIT_ONE] & ~wbyte[ITC_BIT_ONE]; // R14
            reg_d[ITC_BIT_ZERO] = reg_q[ITC_BIT_ZERO] & ~wbyte[ITC_BIT_ZERO]; // R14
         end
      end
      if (reg_q[ITC_BIT_MODE])
      begin
         if (rise)
            reg_d[ITC_BIT_ONE] = 1'b1; // R14
         if (fall)
            reg_d[ITC_BIT_ZERO] = 1'b1; // R14
      end
      // stop recovery resets all but the combining field
      if (stop_recovery)
      begin
         reg_d = ITC_RESET_VAL;
         reg_d[ITC_FLD_HI:ITC_FLD_LO] = reg_q[ITC_FLD_HI:ITC_FLD_LO]; // R7
      end
   end

   // demodulation path; only the second synchroniser stage is read
   assign filt.raw = reg_q[ITC_BIT_SEL] ? p20_s2_q : p31_s2_q; // R4 R15
   assign filt.sel = reg_q[ITC_SUB_HI:ITC_SUB_LO]; // R11
   always_comb
   begin
      rise = 1'b0;
      fall = 1'b0;
      clean_prev_d = filt.clean;
      unique case (itc_edge_t'(reg_q[ITC_FLD_HI:ITC_FLD_LO])) // R8
         ITC_EDGE_FALL: fall = clean_prev_q && !filt.clean;
         ITC_EDGE_RISE: rise = !clean_prev_q && filt.clean;
         ITC_EDGE_BOTH:
         begin
            fall = clean_prev_q && !filt.clean;
            rise = !clean_prev_q && filt.clean;
         end
         ITC_EDGE_RSVD: ;
      endcase
   end

   // transmit path: levels and combining
   always_comb
   begin
      sixteen_hold_d = sixteen_hold_q;
      eight_hold_d = eight_bit_timer_enabled ? 1'b0 : 1'b1;
      alt_d = alt_q;
      if (wr_hit && !wbyte[ITC_BIT_MODE])
      begin
         unique case (itc_sub_t'(wbyte[ITC_SUB_HI:ITC_SUB_LO])) // R9
            ITC_SUB_NORMAL:
            begin
               alt_d = 1'b0;
               sixteen_hold_d = 1'b1; // R10
            end
            ITC_SUB_ALT:
            begin
               alt_d = 1'b1;
               sixteen_hold_d = 1'b1; // R10
            end
            ITC_SUB_FORCE_LO, ITC_SUB_FORCE_HI:
            begin
               // forcing the output is a submode of its own, so alternation stops
               alt_d = 1'b0;
               sixteen_hold_d = 1'b0;
            end
         endcase
      end
      else if (sixteen_bit_timer_counting)
         sixteen_hold_d = 1'b0;
      if (reg_q[ITC_BIT_MODE] || stop_recovery)
         alt_d = 1'b0; // R9
      // a disabled eight-bit timer, or a sixteen-bit timer held since a normal/alternating write, shows the opposite of its initial level
      t8_eff = eight_hold_q ? ~reg_q[ITC_BIT_ONE] : eight_bit_timer_output; // R13
      t16_eff = sixteen_hold_q ? ~reg_q[ITC_BIT_ZERO] : sixteen_bit_timer_output; // R10 R13
      if (reg_q[ITC_SUB_HI:ITC_SUB_LO] == ITC_SUB_FORCE_LO)
         t16_eff = 1'b0; // R9
      else if (reg_q[ITC_SUB_HI:ITC_SUB_LO] == ITC_SUB_FORCE_HI)
         t16_eff = 1'b1; // R9
      unique case (itc_logic_t'(reg_q[ITC_FLD_HI:ITC_FLD_LO])) // R6
         ITC_LOG_AND: comb = t8_eff & t16_eff;
         ITC_LOG_OR: comb = t8_eff | t16_eff;
         ITC_LOG_NOR: comb = ~(t8_eff | t16_eff);
         ITC_LOG_NAND: comb = ~(t8_eff & t16_eff);
      endcase
      p36_d = port3_pin6_port_data;
      if (!reg_q[ITC_BIT_MODE] && reg_q[ITC_BIT_SEL]) // R1 R3
         p36_d = comb;
      t8l_d = t8_eff;
      t16l_d = t16_eff;
      din_d = filt.clean;
      // a port3_pin1 event also reaches interrupt one when unmasked
      irq_d = reg_q[ITC_BIT_MODE] && !reg_q[ITC_BIT_SEL]
         && interrupt_mask_register[ITC_IRQ_MASK_BIT] && (rise || fall); // R5
      ev_d = reg_q[ITC_BIT_MODE] && (rise || fall); // R8
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         reg_q <= ITC_RESET_VAL; // R12
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         bv_q <= 1'b0;
         br_q <= ITC_RESP_OKAY;
         rv_q <= 1'b0;
         rd_q <= '0;
         rr_q <= ITC_RESP_OKAY;
         awrdy_q <= 1'b1;
         wrdy_q <= 1'b1;
         arrdy_q <= 1'b1;
         p31_s1_q <= 1'b0;
         p31_s2_q <= 1'b0;
         p20_s1_q <= 1'b0;
         p20_s2_q <= 1'b0;
         clean_prev_q <= 1'b0;
         eight_hold_q <= 1'b1;
         sixteen_hold_q <= 1'b1;
         alt_q <= 1'b0;
         p36_q <= 1'b0;
         t8l_q <= 1'b1;
         t16l_q <= 1'b1;
         din_q <= 1'b0;
         irq_q <= 1'b0;
         ev_q <= 1'b0;
      end
      else
      begin
         reg_q <= reg_d;
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         awrdy_q <= !aw_d;
         wrdy_q <= !w_d;
         arrdy_q <= !rv_d;
         p31_s1_q <= port3_pin1;
         p31_s2_q <= p31_s1_q;
         p20_s1_q <= port2_pin0;
         p20_s2_q <= p20_s1_q;
         clean_prev_q <= clean_prev_d;
         eight_hold_q <= eight_hold_d;
         sixteen_hold_q <= sixteen_hold_d;
         alt_q <= alt_d;
         p36_q <= p36_d;
         t8l_q <= t8l_d;
         t16l_q <= t16l_d;
         din_q <= din_d;
         irq_q <= irq_d;
         ev_q <= ev_d;
      end
   end

   assign s_axi_awready = awrdy_q;
   assign s_axi_wready = wrdy_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
   assign port3_pin6 = p36_q;
   assign eight_bit_timer_level = t8l_q;
   assign sixteen_bit_timer_level = t16l_q;
   assign alternating_active = alt_q;
   assign demod_input = din_q;
   assign external_interrupt_one = irq_q;
   assign demod_event = ev_q;
endmodule

//--- verif/itc_pin_model.sv
`timescale 1ns/1ps
module itc_pin_model
(
   input wire logic clk_sys,
   output logic port3_pin1,
   output logic port2_pin0
);
   // both pins idle low and move only inside a commanded pulse
   initial
   begin
      port3_pin1 = 1'b0;
      port2_pin0 = 1'b0;
   end
   task automatic pulse(input logic pin, input int width);
      @(posedge clk_sys);
      if (pin) port2_pin0 <= 1'b1;
      else port3_pin1 <= 1'b1;
      repeat (width) @(posedge clk_sys);
      port3_pin1 <= 1'b0;
      port2_pin0 <= 1'b0;
   endtask
endmodule

//--- verif/itc_common_functions_props.sv
`timescale 1ns/1ps
module itc_common_functions_props
   import itc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic stop_recovery,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic port3_pin6_port_data,
   input wire logic [7:0] interrupt_mask_register,
   input wire logic port3_pin6,
   input wire logic sixteen_bit_timer_level,
   input wire logic alternating_active,
   input wire logic external_interrupt_one,
   input wire logic demod_event
);
   logic [7:0] cfg_q, w_q;
   logic [3:0] age_q;
   logic quiet, xmit;
   // mirror trusted only once a write has settled; the register moves as bvalid rises
   assign quiet = age_q > 4'h3 && !s_axi_bvalid;
   assign xmit = quiet && !cfg_q[ITC_BIT_MODE];
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         cfg_q <= 8'h00;
         w_q <= 8'h00;
         age_q <= 4'h0;
      end
      else
      begin
         if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wstrb[ITC_LANE] ? s_axi_wdata[7:0] : cfg_q;
         if (stop_recovery) cfg_q <= cfg_q & 8'h30;
         else if (s_axi_bvalid && s_axi_bready) cfg_q <= w_q;
         if (s_axi_bvalid || stop_recovery) age_q <= 4'h0;
         else if (!quiet) age_q <= age_q + 4'h1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   pin_port_a: assert property (xmit && !cfg_q[ITC_BIT_SEL] |=>
      port3_pin6 == $past(port3_pin6_port_data)) else $error("pin not port data");
   force_lvl_a: assert property (xmit && cfg_q[ITC_SUB_HI] |->
      sixteen_bit_timer_level == cfg_q[ITC_SUB_LO]) else $error("forced level wrong");
   alt_flag_a: assert property (xmit |->
      alternating_active == (cfg_q[3:2] == ITC_SUB_ALT)) else $error("alternating flag wrong");
   irq_mask_a: assert property (external_interrupt_one |->
      $past(interrupt_mask_register[ITC_IRQ_MASK_BIT])) else $error("irq while masked");
   irq_pin_a: assert property (external_interrupt_one |->
      cfg_q[ITC_BIT_MODE] && !cfg_q[ITC_BIT_SEL]) else $error("irq from wrong pin");
   evt_mode_a: assert property (demod_event |-> cfg_q[ITC_BIT_MODE])
      else $error("edge event in transmit mode");
   w_block_a: assert property (s_axi_bvalid |-> !s_axi_wready)
      else $error("wready during response");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready during read data");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (external_interrupt_one);
   cover property (demod_event);
endmodule
bind itc_common_functions itc_common_functions_props i_props (.*);

//--- verif/tb_ir_timer_common_functions.sv
`timescale 1ns/1ps
module tb_ir_timer_common_functions
   import itc_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, stop_recovery = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic eight_bit_timer_output = 1'b0, sixteen_bit_timer_output = 1'b0;
   logic eight_bit_timer_enabled = 1'b0, sixteen_bit_timer_counting = 1'b0;
   logic port3_pin6_port_data = 1'b0;
   logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
   logic [31:0] s_axi_wdata = 32'h0, rnd = 32'hc85f;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [7:0] interrupt_mask_register = 8'h00;
   logic [31:0] s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic port3_pin1, port2_pin0, port3_pin6, eight_bit_timer_level, sixteen_bit_timer_level;
   logic alternating_active, demod_input, external_interrupt_one, demod_event;
   int failures = 0, num_checks = 0, irq_n = 0, evt_n = 0, din_n = 0;
   itc_common_functions i_dut (.*);
   itc_pin_model i_pins (.*);
   always #2.5 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic comb(input logic [1:0] c, input logic a, input logic b);
      return c[0] ? (c[1] ? !(a && b) : (a || b)) : (c[1] ? !(a || b) : (a && b));
   endfunction
   function automatic logic [1:0] flags(input logic [1:0] e, input logic [1:0] f, input int w);
      if ((f == 2'h1 && w <= ITC_FILT_SHORT_CYC) || (f == 2'h2 && w <= ITC_FILT_LONG_CYC))
         return 2'h0;
      return {e != 2'h0, e != 2'h1};
   endfunction
   always @(posedge clk_sys)
   begin
      rnd <= lfsr(rnd);
      port3_pin6_port_data <= rnd[5];
      if (external_interrupt_one === 1'b1) irq_n <= irq_n + 1;
      if (demod_event === 1'b1) evt_n <= evt_n + 1;
      if (demod_input === 1'b1) din_n <= din_n + 1;
   end
   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic hang();
      failures++;
      print_verdict();
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 60);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 60) hang();
   endtask
   task automatic axi_rd(input logic [13:0] a);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 60);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 60) hang();
   endtask
   task automatic rd_reg(input string what, input logic [7:0] exp);
      axi_rd(ITC_ADDR_BYTE);
      check(what, 32'(rd[7:0]), 32'(exp));
      check("read resp", 32'(rsp), 32'(ITC_RESP_OKAY));
   endtask
   task automatic demod(input logic sel, input logic pin, input logic [1:0] e,
      input logic [1:0] f, input int w, input logic m);
      logic [1:0] x;
      x = (pin == sel) ? flags(e, f, w) : 2'h0;
      interrupt_mask_register <= {5'h0, m, 2'h0} | (rnd[7:0] & 8'hfb);
      axi_wr(ITC_ADDR_BYTE, {1'b1, sel, e, f, 2'h3}, 4'h1);
      repeat (20) @(posedge clk_sys);
      irq_n = 0;
      evt_n = 0;
      din_n = 0;
      i_pins.pulse(pin, w);
      repeat (20) @(posedge clk_sys);
      check("irq", 32'(irq_n != 0), 32'(m && !sel && !pin && x != 2'h0));
      check("events", 32'(evt_n), 32'(x[0]) + 32'(x[1]));
      check("filtered width", 32'(din_n), (x != 2'h0) ? 32'(w) : 32'h0);
      rd_reg("edge flags", {1'b1, sel, e, f, x});
      axi_wr(ITC_ADDR_BYTE, {1'b1, sel, e, f, 2'h3}, 4'h1);
      rd_reg("flags cleared", {1'b1, sel, e, f, 2'h0});
   endtask
   initial
   begin
      int i;
      logic [7:0] v;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd_reg("reset value", ITC_RESET_VAL);
      axi_wr(14'h104, 8'hff, 4'h0);
      check("bad write resp", 32'(rsp), 32'(ITC_RESP_SLVERR));
      axi_rd(14'h104);
      check("bad read resp", 32'(rsp), 32'(ITC_RESP_SLVERR));
      check("bad read data", rd, 32'h0);
      for (i = 0; i < 4; i++)
      begin
         v = rnd[7:0] & 8'h7f;
         axi_wr(ITC_ADDR_BYTE, v, rnd[11:8] | 4'h1);
         rd_reg("readback", v);
      end
      axi_wr(ITC_ADDR_BYTE, 8'h55, 4'he);
      rd_reg("lane off write", v);
      axi_wr(ITC_ADDR_BYTE, 8'h6e, 4'h1);
      stop_recovery <= 1'b1;
      @(posedge clk_sys);
      stop_recovery <= 1'b0;
      rd_reg("stop recovery", 8'h20);
      eight_bit_timer_enabled <= 1'b1;
      sixteen_bit_timer_counting <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         if (i % 4 == 0) axi_wr(ITC_ADDR_BYTE, 8'h40 | 8'(i * 4), 4'h1);
         eight_bit_timer_output <= i[0];
         sixteen_bit_timer_output <= i[1];
         repeat (4) @(posedge clk_sys);
         check("combined pin", 32'(port3_pin6), 32'(comb(2'(i / 4), i[0], i[1])));
      end
      eight_bit_timer_enabled <= 1'b0;
      sixteen_bit_timer_counting <= 1'b0;
      axi_wr(ITC_ADDR_BYTE, 8'h01, 4'h1);
      repeat (4) @(posedge clk_sys);
      check("eight idle level", 32'(eight_bit_timer_level), 32'h1);
      check("sixteen held level", 32'(sixteen_bit_timer_level), 32'h0);
      sixteen_bit_timer_counting <= 1'b1;
      sixteen_bit_timer_output <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("sixteen running", 32'(sixteen_bit_timer_level), 32'h1);
      for (i = 0; i < 4; i++)
      begin
         axi_wr(ITC_ADDR_BYTE, 8'(i * 4), 4'h1);
         repeat (4) @(posedge clk_sys);
         check("alternating", 32'(alternating_active), 32'(i == 1));
         if (i > 1) check("forced level", 32'(sixteen_bit_timer_level), 32'(i - 2));
      end
      // both timers stopped before the mode bit flips
      eight_bit_timer_enabled <= 1'b0;
      sixteen_bit_timer_counting <= 1'b0;
      axi_wr(ITC_ADDR_BYTE, 8'h80, 4'h1);
      demod(1'b0, 1'b0, ITC_EDGE_FALL, ITC_FILT_NONE, 3, 1'b1);
      demod(1'b0, 1'b0, ITC_EDGE_RISE, ITC_FILT_SHORT, 6, 1'b1);
      demod(1'b1, 1'b1, ITC_EDGE_BOTH, ITC_FILT_LONG, 12, 1'b0);
      demod(1'b1, 1'b1, ITC_EDGE_BOTH, ITC_FILT_LONG, 6, 1'b0);
      demod(1'b1, 1'b0, ITC_EDGE_BOTH, ITC_FILT_NONE, 6, 1'b1);
      demod(1'b0, 1'b0, ITC_EDGE_BOTH, ITC_FILT_SHORT, 2, 1'b1);
      demod(1'b0, 1'b0, ITC_EDGE_BOTH, ITC_FILT_SHORT, 6, 1'b0);
      print_verdict();
   end
endmodule
